/* dv/flash_dev_model.sv */
// behavioural boot-sector flash device on the far side of the host pins
// assumes the bench resolves the shared data lines and feeds the wire level on dq
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
    parameter bit         TOP_BOOT = 1'b1,
    parameter int         DLY_NS   = 90,
    parameter logic [7:0] MANUF    = 8'h5A, // arbitrary value
    parameter logic [7:0] DEVICE   = 8'h6B, // arbitrary value
    parameter logic [7:0] CONT     = 8'h4D  // arbitrary value
) (
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        rst_n,
    input  wire logic        hv_a9,
    input  wire logic        hv_ctl,
    input  wire logic [17:0] addr,
    input  wire logic [15:0] dq,
    output var  logic [15:0] dq_rd
);
    logic [15:0] mem [int];
    logic        prot [11] = '{default: 1'b0};
    logic [1:0]  unl = 2'h0;
    logic        idm = 1'b0;
    logic        pgm = 1'b0;
    logic        ers = 1'b0;
    logic        drv;
    logic [15:0] val;
    logic [15:0] last = 16'h0000;

    function automatic int sec_of(logic [17:0] a);
        if (TOP_BOOT)
            return a[17:15] != 3'h7 ? int'(a[17:15]) : !a[14] ? 7 : a[13] ? 10 : 8 + int'(a[12]);
        return a[17:15] != 3'h0 ? int'(a[17:15]) + 3 : a[14] ? 3 : a[13] ? 1 + int'(a[12]) : 0;
    endfunction

    always @(negedge rst_n) begin
        {unl, idm, pgm, ers} = '0;
    end
    // data taken at the rising write strobe
    always @(posedge we_n) begin
        if (!ce_n && oe_n && rst_n) begin
            if (hv_a9 && hv_ctl)
                prot[sec_of(addr)] = dq[0];
            else if (pgm) begin
                if (!prot[sec_of(addr)]) mem[addr] = dq;
                pgm = 1'b0;
            end else if (dq[7:0] == 8'hF0)
                {unl, idm} = '0;
            else if (unl == 2'h0 && addr == 18'h00555 && dq[7:0] == 8'hAA)
                unl = 2'h1;
            else if (unl == 2'h1 && addr == 18'h002AA && dq[7:0] == 8'h55)
                unl = 2'h2;
            else if (unl == 2'h2 && ers && dq[7:0] == 8'h30) begin
                // sector erase leaves written words reading all ones
                if (!prot[sec_of(addr)])
                    foreach (mem[k])
                        if (sec_of(18'(k)) == sec_of(addr)) mem[k] = 16'hFFFF;
                {unl, ers} = '0;
            end else if (unl == 2'h2 && addr == 18'h00555) begin
                idm = idm || dq[7:0] == 8'h90;
                pgm = dq[7:0] == 8'hA0;
                ers = dq[7:0] == 8'h80;
                unl = 2'h0;
            end else
                {unl, ers} = '0;
        end
    end
    always @* begin
        drv = rst_n && !ce_n && !oe_n && we_n;
        val = mem.exists(addr) ? mem[addr] : addr[15:0] ^ 16'h5A3C;
        if (idm || (hv_a9 && !addr[6])) begin
            case (addr[1:0])
                2'h0: val = {8'hC3, MANUF};
                2'h1: val = {8'hC3, DEVICE};
                2'h2: val = {8'hC3, 7'h00, prot[sec_of(addr)]};
                default: val = {8'hC3, CONT};
            endcase
        end
    end
    // released lines show the inverse of the last value, never a stale copy
    always @* if (drv) last = val;
    assign #(DLY_NS) dq_rd = drv ? val : ~last;
endmodule // flash_dev_model
`default_nettype wire

/* dv/flash_host_sva.sv */
// concurrent checks on the flash host pins
// assumes it is bound onto flash_host and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module flash_host_sva
    import flash_host_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        flash_rst_n,
    input  wire logic        hv_a9,
    input  wire logic [17:0] addr,
    input  wire logic [15:0] dq_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    int low_cnt;
    // cycles the flash reset pin has been low
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            low_cnt <= 0;
        else
            low_cnt <= flash_rst_n ? 0 : low_cnt + 1;
    end
    sequence s_wr_pulse;
        (!we_n && !ce_n && oe_n) [*3];
    endsequence
    sequence s_rd_pulse;
        (!oe_n && !ce_n && we_n) [*8];
    endsequence
    AST_RST_HOLD: assert property ($rose(flash_rst_n) |-> low_cnt >= TRP_CYC)
        else $error("flash reset pulse too short");
    AST_RST_QUIET: assert property (!flash_rst_n |-> we_n && oe_n)
        else $error("strobe active during flash reset");
    AST_WR_LEVELS: assert property (!we_n |-> !ce_n && oe_n)
        else $error("write strobe without select or with gate low");
    AST_WE_WIDTH: assert property ($fell(we_n) |-> s_wr_pulse)
        else $error("write strobe pulse too short");
    AST_WR_DRIVE: assert property ($fell(we_n) |-> dq_oe == 16'hFFFF)
        else $error("data lines not driven in write");
    AST_RD_FLOAT: assert property (!oe_n |-> we_n && dq_oe == 16'h0000)
        else $error("host drives data while gate low");
    AST_RD_WIDTH: assert property ($fell(oe_n) |-> s_rd_pulse)
        else $error("read gate pulse too short");
    AST_HV_LOW: assert property (hv_a9 && !oe_n |-> !addr[6] && !addr[9])
        else $error("id address bits not low");
endmodule // flash_host_sva

bind flash_host flash_host_sva u_flash_host_sva (
    .mclk, .arst_n, .ce_n, .oe_n, .we_n, .flash_rst_n, .hv_a9, .addr, .dq_oe
);
`default_nettype wire

/* dv/flash_host_tb.sv */
// self-checking bench: flash host against a behavioural flash device
// assumes the device model answers inside the host read window
`timescale 1ns/100ps
`default_nettype none
module flash_host_tb;
    import flash_host_pkg::*;
    typedef struct {op_t op; logic [17:0] a; logic [3:0] s;
                    logic [15:0] w; logic c; logic [15:0] e;} row_t;
    logic        mclk, arst_n, cmd_valid, cmd_ready, done, aborted, ce_n, oe_n, we_n;
    logic        flash_rst_n, byte_n, hv_a9, hv_ctl;
    logic [17:0] addr;
    logic [15:0] rdata, dq_out, dq_oe, dq_rd, dq_w;
    cmd_t        cmd;
    int          errors = 0;
    int          tests_run = 0;
    int          i;
    row_t        rows [19] = '{
        '{OP_READ, 18'h100, 4'h0, 16'h0, 1'b1, 16'h5B3C},
        '{OP_HV_ID, 18'h0, 4'h0, 16'h0, 1'b1, 16'h005A},
        '{OP_HV_ID, 18'h1, 4'h0, 16'h0, 1'b1, 16'h006B},
        '{OP_HV_ID, 18'h3, 4'h0, 16'h0, 1'b1, 16'h004D},
        '{OP_HV_ID, 18'h2, 4'h8, 16'h0, 1'b1, 16'h0000},
        '{OP_HV_PROTECT, 18'h0, 4'h8, 16'h1, 1'b0, 16'h0},
        '{OP_HV_ID, 18'h2, 4'h8, 16'h0, 1'b1, 16'h0001},
        '{OP_PROGRAM, 18'h3C010, 4'h0, 16'h1234, 1'b0, 16'h0},
        '{OP_READ, 18'h3C010, 4'h0, 16'h0, 1'b1, 16'h9A2C},
        '{OP_PROGRAM, 18'h100, 4'h0, 16'hBEEF, 1'b0, 16'h0},
        '{OP_READ, 18'h100, 4'h0, 16'h0, 1'b1, 16'hBEEF},
        '{OP_ID_ENTER, 18'h0, 4'h0, 16'h0, 1'b0, 16'h0},
        '{OP_ID_READ, 18'h0, 4'h0, 16'h0, 1'b1, 16'h005A},
        '{OP_ID_READ, 18'h2, 4'h8, 16'h0, 1'b1, 16'h0001},
        '{OP_ID_EXIT, 18'h0, 4'h0, 16'h0, 1'b0, 16'h0},
        '{OP_READ, 18'h100, 4'h0, 16'h0, 1'b1, 16'hBEEF},
        '{OP_HV_PROTECT, 18'h0, 4'h8, 16'h0, 1'b0, 16'h0},
        '{OP_PROGRAM, 18'h3C010, 4'h0, 16'h1234, 1'b0, 16'h0},
        '{OP_READ, 18'h3C010, 4'h0, 16'h0, 1'b1, 16'h1234}
    };

    assign dq_w = (dq_out & dq_oe) | (dq_rd & ~dq_oe);

    flash_host u_flash_host (
        .mclk, .arst_n, .cmd_valid, .cmd, .cmd_ready, .done, .rdata, .aborted,
        .ce_n, .oe_n, .we_n, .flash_rst_n, .byte_n, .hv_a9, .hv_ctl, .addr,
        .dq_out, .dq_oe, .dq_in(dq_w)
    );
    flash_dev_model u_flash_dev_model (
        .ce_n, .oe_n, .we_n, .rst_n(flash_rst_n), .hv_a9, .hv_ctl, .addr,
        .dq(dq_w), .dq_rd
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // hold the request until the edge that takes it; a hardware reset is taken at once
    task automatic issue(op_t op, logic [17:0] a, logic [3:0] s, logic [15:0] w);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd = '{op, a, 1'b0, s, w};
        do @(posedge mclk); while (cmd_ready !== 1'b1 && op != OP_HW_RESET);
        @(negedge mclk);
        cmd_valid = 1'b0;
    endtask
    task automatic run(op_t op, logic [17:0] a, logic [3:0] s, logic [15:0] w);
        int n;
        issue(op, a, s, w);
        for (n = 0; n < 300 && done !== 1'b1; n++) @(negedge mclk);
        chk("done", {15'h0, done}, 16'h0001);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        repeat (12) @(negedge mclk);
        chk("rst pins", {11'h0, ce_n, oe_n, we_n, flash_rst_n, cmd_ready}, 16'h001C);
        chk("rst dq_oe", dq_oe, 16'h0000);
        arst_n = 1'b1;
        repeat (TRP_CYC - 1) @(negedge mclk);
        chk("rst held", {15'h0, flash_rst_n}, 16'h0000);
        chk("width", {15'h0, byte_n}, 16'h0001);
        for (i = 0; i < 19; i++) begin
            run(rows[i].op, rows[i].a, rows[i].s, rows[i].w);
            if (rows[i].c) chk($sformatf("row %0d", i), rdata, rows[i].e);
        end
        // hardware reset cuts a program at the start of its second bus cycle
        issue(OP_PROGRAM, 18'h200, 4'h0, 16'h1111);
        repeat (5) @(negedge mclk);
        run(OP_HW_RESET, 18'h0, 4'h0, 16'h0);
        chk("abort", {15'h0, aborted}, 16'h0001);
        run(OP_READ, 18'h200, 4'h0, 16'h0);
        chk("cut program", rdata, 16'h583C);
        chk("abort clear", {15'h0, aborted}, 16'h0000);
        run(OP_ID_ENTER, 18'h0, 4'h0, 16'h0);
        run(OP_HW_RESET, 18'h0, 4'h0, 16'h0);
        run(OP_READ, 18'h100, 4'h0, 16'h0);
        chk("read after reset", rdata, 16'hBEEF);
        for (i = 0; i < NUM_SECTORS; i++) run(OP_HV_PROTECT, 18'h0, 4'(i), {15'h0, i[0]});
        for (i = 0; i < NUM_SECTORS; i++) begin
            run(OP_HV_ID, 18'h2, 4'(i), 16'h0);
            chk($sformatf("sector %0d", i), rdata, {15'h0, i[0]});
        end
        // sector erase: an open sector reads erased, a protected one keeps its word
        run(OP_ERASE, 18'h0, 4'h8, 16'h0);
        run(OP_READ, 18'h3C010, 4'h0, 16'h0);
        chk("erase open", rdata, 16'hFFFF);
        run(OP_HV_PROTECT, 18'h0, 4'h0, 16'h1);
        run(OP_ERASE, 18'h0, 4'h0, 16'h0);
        run(OP_READ, 18'h100, 4'h0, 16'h0);
        chk("erase protected", rdata, 16'hBEEF);
        test_done;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        test_done;
    end
endmodule // flash_host_tb
`default_nettype wire

/* rtl/flash_host.sv */
// host controller driving an asynchronous boot-sector flash through its pins
// assumes a programmer supplies the high id voltage when hv_a9 / hv_ctl are high
`timescale 1ns/100ps
`default_nettype none
module flash_host
    import flash_host_pkg::*;
#(
    parameter bit          TOP_BOOT  = 1'b1,
    parameter bit          BYTE_MODE = 1'b0,
    parameter logic [17:0] UNLOCK_A1 = 18'h00555,
    parameter logic [17:0] UNLOCK_A2 = 18'h002AA,
    parameter logic [15:0] UNLOCK_D1 = 16'h00AA,
    parameter logic [15:0] UNLOCK_D2 = 16'h0055,
    parameter logic [15:0] CMD_PROG  = 16'h00A0,
    parameter logic [15:0] CMD_ESET  = 16'h0080,
    parameter logic [15:0] CMD_ESEC  = 16'h0030,
    parameter logic [15:0] CMD_ID    = 16'h0090,
    parameter logic [15:0] CMD_RESET = 16'h00F0
) (
    input  wire logic                  mclk,
    input  wire logic                  arst_n,
    input  wire logic                  cmd_valid,
    input  wire flash_host_pkg::cmd_t  cmd,
    output var  logic                  cmd_ready,
    output var  logic                  done,
    output var  logic [15:0]           rdata,
    output var  logic                  aborted,
    output var  logic                  ce_n,
    output var  logic                  oe_n,
    output var  logic                  we_n,
    output var  logic                  flash_rst_n,
    output var  logic                  byte_n,
    output var  logic                  hv_a9,
    output var  logic                  hv_ctl,
    output var  logic [17:0]           addr,
    output var  logic [15:0]           dq_out,
    output var  logic [15:0]           dq_oe,
    input  wire logic [15:0]           dq_in
);
    import flash_host_pkg::*;

    localparam logic [15:0] TRP_C  = 16'(TRP_CYC);
    localparam logic [15:0] TRH_C  = 16'(TRH_CYC);
    localparam logic [15:0] TWP_C  = 16'(TWP_CYC);
    // access time and the SYNC_CYC synchroniser stages, plus one edge to land in stage one, one for stages two and three
    // to agree, and one because the capture reads the registered synchroniser output
    localparam logic [15:0] TACC_C = 16'(TACC_CYC + SYNC_CYC + 3);

    typedef struct packed {
        state_t      st;
        logic [3:0]  step;
        logic [15:0] cnt;
        cmd_t        c;
        pins_t       p;
        logic [15:0] rdata;
        logic        done;
        logic        ready;
        logic        aborted;
    } host_t;

    localparam pins_t PINS_RST = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0,
                                   byte_n: ~BYTE_MODE, hv_a9: 1'b0, hv_ctl: 1'b0,
                                   addr: 18'h00000, dq_out: 16'h0000, dq_oe: 16'h0000};
    localparam host_t HOST_RST = '{st: S_RST, step: 4'h0, cnt: TRP_C, c: '0,
                                  p: PINS_RST, rdata: 16'h0000, done: 1'b0,
                                  ready: 1'b0, aborted: 1'b0};

    host_t       q;
    host_t       next_q;
    logic [15:0] dq_sync;
    bus_cycle_t  cyc;

    pin_sync #(.WIDTH(16)) u_dq_sync (
        .mclk   (mclk),
        .arst_n (arst_n),
        .din    (dq_in),
        .dout   (dq_sync)
    );

    // sector index to A17..A12, per boot variant
    function automatic logic [5:0] sector_bits(input logic [3:0] idx);
        logic [3:0] k;
        k = 4'h0;
        if (TOP_BOOT) begin
            if (idx < 4'(NUM_BIG)) begin
                sector_bits = {idx[2:0], 3'b000};
            end else begin
                unique case (idx)
                    4'h7:    sector_bits = 6'b111000;
                    4'h8:    sector_bits = 6'b111100;
                    4'h9:    sector_bits = 6'b111101;
                    default: sector_bits = 6'b111110;
                endcase
            end
        end else begin
            k = idx - 4'h3;
            unique case (idx)
                4'h0:    sector_bits = 6'b000000;
                4'h1:    sector_bits = 6'b000010;
                4'h2:    sector_bits = 6'b000011;
                4'h3:    sector_bits = 6'b000100;
                default: sector_bits = {k[2:0], 3'b000};
            endcase
        end
    endfunction

    function automatic bus_cycle_t mk(input logic wr, input logic last, input logic hv,
                                      input logic [17:0] a, input logic [15:0] d);
        mk = '{wr: wr, last: last, hv: hv, addr: a, data: d};
    endfunction

    // one bus cycle of the sequence for an operation
    function automatic bus_cycle_t seq_cycle(input cmd_t c, input logic [3:0] step);
        logic [17:0] sa_addr;
        logic [17:0] id_addr;
        sa_addr = {sector_bits(c.sector), 12'h000};
        id_addr = {sector_bits(c.sector), 10'h000, c.addr[1:0]};
        seq_cycle = mk(1'b0, 1'b1, 1'b0, c.addr, 16'h0000);
        unique case (c.op)
            OP_PROGRAM: begin
                unique case (step)
                    4'h0:    seq_cycle = mk(1'b1, 1'b0, 1'b0, UNLOCK_A1, UNLOCK_D1);
                    4'h1:    seq_cycle = mk(1'b1, 1'b0, 1'b0, UNLOCK_A2, UNLOCK_D2);
                    4'h2:    seq_cycle = mk(1'b1, 1'b0, 1'b0, UNLOCK_A1, CMD_PROG);
                    default: seq_cycle = mk(1'b1, 1'b1, 1'b0, c.addr, c.wdata);
                endcase
            end
            OP_ERASE: begin
                unique case (step)
                    4'h0, 4'h3: seq_cycle = mk(1'b1, 1'b0, 1'b0, UNLOCK_A1, UNLOCK_D1);
                    4'h1, 4'h4: seq_cycle = mk(1'b1, 1'b0, 1'b0, UNLOCK_A2, UNLOCK_D2);
                    4'h2:       seq_cycle = mk(1'b1, 1'b0, 1'b0, UNLOCK_A1, CMD_ESET);
                    default:    seq_cycle = mk(1'b1, 1'b1, 1'b0, sa_addr, CMD_ESEC);
                endcase
            end
            OP_ID_ENTER: begin
                unique case (step)
                    4'h0:    seq_cycle = mk(1'b1, 1'b0, 1'b0, UNLOCK_A1, UNLOCK_D1);
                    4'h1:    seq_cycle = mk(1'b1, 1'b0, 1'b0, UNLOCK_A2, UNLOCK_D2);
                    default: seq_cycle = mk(1'b1, 1'b1, 1'b0, UNLOCK_A1, CMD_ID);
                endcase
            end
            OP_ID_READ:    seq_cycle = mk(1'b0, 1'b1, 1'b0, id_addr, 16'h0000);
            OP_ID_EXIT:    seq_cycle = mk(1'b1, 1'b1, 1'b0, UNLOCK_A1, CMD_RESET);
            OP_HV_ID:      seq_cycle = mk(1'b0, 1'b1, 1'b1, id_addr, 16'h0000);
            OP_HV_PROTECT: seq_cycle = mk(1'b1, 1'b1, 1'b1, sa_addr, c.wdata);
            default:       seq_cycle = mk(1'b0, 1'b1, 1'b0, c.addr, 16'h0000);
        endcase
    endfunction

    always_comb begin
        next_q = q;
        next_q.done = 1'b0;
        cyc = seq_cycle(q.c, q.step);
        if (cmd_valid && cmd.op == OP_HW_RESET) begin
            // taken in any state; cuts short whatever runs
            next_q.aborted = (q.st != S_IDLE) && (q.st != S_RST) && (q.st != S_RREC);
            next_q.c = cmd;
            next_q.st = S_RST;
            next_q.cnt = TRP_C;
            next_q.p = PINS_RST;
        end else begin
            unique case (q.st)
                S_IDLE: begin
                    if (cmd_valid) begin
                        next_q.c = cmd;
                        next_q.step = 4'h0;
                        next_q.aborted = 1'b0;
                        next_q.st = S_SETUP;
                    end
                end
                S_RST: begin
                    next_q.cnt = q.cnt - 16'h0001;
                    if (q.cnt == 16'h0001) begin
                        next_q.p.rst_n = 1'b1;
                        next_q.cnt = TRH_C;
                        next_q.st = S_RREC;
                    end
                end
                S_RREC: begin
                    next_q.cnt = q.cnt - 16'h0001;
                    if (q.cnt == 16'h0001) begin
                        next_q.done = (q.c.op == OP_HW_RESET);
                        next_q.st = S_IDLE;
                    end
                end
                S_SETUP: begin
                    next_q.p.addr = cyc.addr;
                    next_q.p.ce_n = 1'b0;
                    next_q.p.oe_n = 1'b1;
                    next_q.p.hv_a9 = cyc.hv;
                    next_q.p.hv_ctl = cyc.hv && cyc.wr;
                    next_q.p.dq_out = cyc.data;
                    if (BYTE_MODE) begin
                        next_q.p.dq_out[15] = q.c.lsb;
                        next_q.p.dq_oe = {1'b1, 7'h00, {8{cyc.wr}}};
                    end else begin
                        next_q.p.dq_oe = {16{cyc.wr}};
                    end
                    next_q.st = cyc.wr ? S_STROBE : S_READ;
                    next_q.cnt = cyc.wr ? TWP_C : TACC_C;
                end
                S_STROBE: begin
                    next_q.p.we_n = 1'b0;
                    next_q.cnt = q.cnt - 16'h0001;
                    if (q.cnt == 16'h0001) begin
                        next_q.st = S_END;
                    end
                end
                S_READ: begin
                    next_q.p.oe_n = 1'b0;
                    next_q.cnt = q.cnt - 16'h0001;
                    if (q.cnt == 16'h0001) begin
                        if (BYTE_MODE || q.c.op == OP_ID_READ || q.c.op == OP_HV_ID) begin
                            next_q.rdata = {8'h00, dq_sync[7:0]};
                        end else begin
                            next_q.rdata = dq_sync;
                        end
                        next_q.st = S_END;
                    end
                end
                S_END: begin
                    // strobes rise first, then select and bus release a cycle later
                    if (!q.p.we_n || !q.p.oe_n) begin
                        next_q.p.we_n = 1'b1;
                        next_q.p.oe_n = 1'b1;
                    end else begin
                        next_q.p.ce_n = 1'b1;
                        next_q.p.dq_oe = 16'h0000;
                        next_q.p.hv_ctl = 1'b0;
                        if (cyc.last) begin
                            next_q.p.hv_a9 = 1'b0;
                            next_q.done = 1'b1;
                            next_q.st = S_IDLE;
                        end else begin
                            next_q.step = q.step + 4'h1;
                            next_q.st = S_SETUP;
                        end
                    end
                end
            endcase
        end
        next_q.ready = (next_q.st == S_IDLE);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= HOST_RST;
        end else begin
            q <= next_q;
        end
    end

    assign cmd_ready   = q.ready;
    assign done        = q.done;
    assign rdata       = q.rdata;
    assign aborted     = q.aborted;
    assign ce_n        = q.p.ce_n;
    assign oe_n        = q.p.oe_n;
    assign we_n        = q.p.we_n;
    assign flash_rst_n = q.p.rst_n;
    assign byte_n      = q.p.byte_n;
    assign hv_a9       = q.p.hv_a9;
    assign hv_ctl      = q.p.hv_ctl;
    assign addr        = q.p.addr;
    assign dq_out      = q.p.dq_out;
    assign dq_oe       = q.p.dq_oe;
endmodule // flash_host
`default_nettype wire

/* rtl/flash_host_pkg.sv */
// shared types and constants of the boot-sector flash host controller
// assumes one 50 MHz clock and an asynchronous parallel flash on the far pins
package flash_host_pkg;

    localparam int CLK_PERIOD_NS = 20;
    localparam int T_RP_NS       = 500;
    localparam int T_RH_NS       = 100;
    localparam int T_WP_NS       = 60;
    localparam int T_ACC_NS      = 120;

    // least times round up to whole cycles, never below one
    localparam int TRP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRH_CYC = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TWP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CYC = 3;

    localparam logic [1:0] ID_MANUF   = 2'h0;
    localparam logic [1:0] ID_DEVICE  = 2'h1;
    localparam logic [1:0] ID_PROTECT = 2'h2;
    localparam logic [1:0] ID_CONT    = 2'h3;

    localparam int NUM_SECTORS   = 11;
    localparam int NUM_BIG       = 7;
    localparam logic [7:0] PROTECTED_CODE = 8'h01;

    typedef enum logic [3:0] {
        OP_READ       = 4'h0,
        OP_PROGRAM    = 4'h1,
        OP_ERASE      = 4'h2,
        OP_ID_ENTER   = 4'h3,
        OP_ID_READ    = 4'h4,
        OP_ID_EXIT    = 4'h5,
        OP_HW_RESET   = 4'h6,
        OP_HV_ID      = 4'h7,
        OP_HV_PROTECT = 4'h8
    } op_t;

    typedef enum logic [6:0] {
        S_IDLE   = 7'b0000001,
        S_RST    = 7'b0000010,
        S_RREC   = 7'b0000100,
        S_SETUP  = 7'b0001000,
        S_STROBE = 7'b0010000,
        S_READ   = 7'b0100000,
        S_END    = 7'b1000000
    } state_t;

    typedef struct packed {
        op_t         op;
        logic [17:0] addr;
        logic        lsb;
        logic [3:0]  sector;
        logic [15:0] wdata;
    } cmd_t;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        rst_n;
        logic        byte_n;
        logic        hv_a9;
        logic        hv_ctl;
        logic [17:0] addr;
        logic [15:0] dq_out;
        logic [15:0] dq_oe;
    } pins_t;

    typedef struct packed {
        logic        wr;
        logic        last;
        logic        hv;
        logic [17:0] addr;
        logic [15:0] data;
    } bus_cycle_t;

endpackage

/* rtl/pin_sync.sv */
// three-stage synchroniser for pin inputs; a bit changes once stages two and three agree
// assumes inputs arrive asynchronously to mclk
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] o;
    } sync_t;

    sync_t q;
    sync_t next_q;

    always_comb begin
        next_q = q;
        next_q.s1 = din;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                next_q.o[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign dout = q.o;
endmodule // pin_sync
`default_nettype wire
